// File: sim/dmsc_host_model.sv
// host model: three-wire master and two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module dmsc_host_model (
  // clock
  input wire logic core_clk,
  // three-wire pins
  output logic three_wire_clock_in,
  output logic three_wire_select_n,
  output logic three_wire_serial_in,
  input wire logic three_wire_serial_out,
  input wire logic three_wire_serial_out_oe,
  // two-wire pins, data resolved against the pull-up
  output logic scl_i,
  output logic sda_i,
  input wire logic sda_oe
);
  localparam int Q = 6;
  logic sda_h;
  assign sda_i = sda_h && !sda_oe;
  initial begin
    three_wire_clock_in = 1'b0;
    three_wire_select_n = 1'b1;
    three_wire_serial_in = 1'b0;
    scl_i = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // leaves select low so the bench can look at the bank before the commit
  task automatic tw_shift(input logic [71:0] d, output logic [71:0] q);
    three_wire_select_n <= 1'b0;
    tick(8);
    for (int i = 71; i >= 0; i--) begin
      three_wire_serial_in <= d[i];
      tick(2);
      three_wire_clock_in <= 1'b1;
      tick(4);
      // a floating readback pin reads as the opposite level, so a missing drive shows
      q[i] = three_wire_serial_out_oe ? three_wire_serial_out : ~three_wire_serial_out;
      three_wire_clock_in <= 1'b0;
      tick(2);
    end
  endtask
  task automatic tw_end();
    tick(2);
    three_wire_select_n <= 1'b1;
    three_wire_serial_in <= ~three_wire_serial_in;
    tick(10);
  endtask
  task automatic start();
    sda_h <= 1'b1;
    tick(Q);
    scl_i <= 1'b1;
    tick(Q);
    sda_h <= 1'b0;
    tick(Q);
    scl_i <= 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    tick(Q);
    scl_i <= 1'b1;
    tick(Q);
    sda_h <= 1'b1;
    tick(Q);
  endtask
  // ack_in high releases the line: no acknowledge from the controller
  task automatic xfer(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                      output logic ack);
    logic [8:0] w;
    w = {b, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_h <= w[i];
      tick(Q);
      scl_i <= 1'b1;
      tick(Q);
      if (i > 0) r[i-1] = sda_i;
      else ack = sda_i;
      tick(Q);
      scl_i <= 1'b0;
      tick(Q);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/dmsc_top_asserts.sv
// property checker for the dual-mode serial control port
`timescale 1ns/1ps
`default_nettype none
module dmsc_top_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic interface_mode_select,
  input wire logic three_wire_clock_in,
  input wire logic three_wire_select_n,
  input wire logic three_wire_serial_out,
  input wire logic three_wire_serial_out_oe,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic [8:0][7:0] ctrl_bank,
  input wire logic monitor_off,
  input wire logic sequence_length_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // age since the last host clock fall; both phases are equal, so only age tells fall from rise
  logic clk_q;
  logic [3:0] fall_age;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      fall_age <= 4'hF;
    end else begin
      clk_q <= three_wire_clock_in;
      fall_age <= (clk_q && !three_wire_clock_in) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
    end
  end
  chk_tw_mode_quiet: assert property (!interface_mode_select [*8] |-> !sda_oe)
    else $error("data line pulled in three-wire mode");
  chk_i2c_mode_quiet: assert property (interface_mode_select [*8] |-> !three_wire_serial_out_oe)
    else $error("readback driven in two-wire mode");
  chk_out_float: assert property (three_wire_select_n [*8] |-> !three_wire_serial_out_oe)
    else $error("readback driven while deselected");
  chk_out_drive: assert property ((!three_wire_select_n && !interface_mode_select) [*8]
    |-> three_wire_serial_out_oe)
    else $error("readback not driven while selected");
  chk_bank_on_sel: assert property ($changed(ctrl_bank) |-> three_wire_select_n)
    else $error("bank changed while selected");
  chk_cfg_zero: assert property (ctrl_bank[8][0] == 1'b0)
    else $error("fixed bit of register nine set");
  chk_cfg_fields: assert property (!three_wire_select_n
    |-> $stable({monitor_off, sequence_length_select}))
    else $error("register nine fields moved inside a frame");
  chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock high");
  chk_out_fall_edge: assert property (three_wire_serial_out_oe
    && $past(three_wire_serial_out_oe) && $changed(three_wire_serial_out)
    |-> fall_age >= 4'h2 && fall_age <= 4'h7)
    else $error("readback moved away from a clock fall");
endmodule
bind dmsc_top dmsc_top_asserts i_dmsc_top_asserts (.core_clk, .rst_n, .interface_mode_select,
  .three_wire_clock_in, .three_wire_select_n, .three_wire_serial_out, .three_wire_serial_out_oe,
  .scl_i, .sda_oe, .ctrl_bank, .monitor_off, .sequence_length_select);
`default_nettype wire

// File: sim/dmsc_top_test.sv
// self-checking bench of the dual-mode serial control port
`timescale 1ns/1ps
`default_nettype none
module dmsc_top_test;
  logic core_clk, rst_n, interface_mode_select, three_wire_clock_in, three_wire_select_n;
  logic three_wire_serial_in, three_wire_serial_out, three_wire_serial_out_oe;
  logic scl_i, sda_i, sda_o, sda_oe, monitor_off, sequence_length_select;
  logic [6:0] i2c_addr_pin;
  logic [8:0][7:0] ctrl_bank, expb;
  logic [71:0] f, q;
  int bad_count = 0;
  int n_checks = 0;
  dmsc_top i_dmsc_top (.core_clk, .rst_n, .interface_mode_select, .i2c_addr_pin,
    .three_wire_clock_in, .three_wire_select_n, .three_wire_serial_in, .three_wire_serial_out,
    .three_wire_serial_out_oe, .scl_i, .sda_i, .sda_o, .sda_oe, .ctrl_bank, .monitor_off,
    .sequence_length_select);
  dmsc_host_model i_dmsc_host_model (.core_clk, .three_wire_clock_in, .three_wire_select_n,
    .three_wire_serial_in, .three_wire_serial_out, .three_wire_serial_out_oe, .scl_i, .sda_i,
    .sda_oe);
  task automatic chk(input logic [71:0] s, input logic [71:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [71:0] fr(input logic [8:0][7:0] b);
    for (int k = 0; k < 9; k++) fr[71-8*k -: 8] = b[k];
  endfunction
  function automatic logic [7:0] rx(input logic [3:0] j);
    rx = (j >= 4'h1 && j <= 4'h9) ? expb[j-4'h1] : 8'h00;
  endfunction
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d[$],
                        input logic na);
    logic [7:0] r;
    logic k;
    i_dmsc_host_model.start();
    i_dmsc_host_model.xfer({a, 1'b0}, 1'b1, r, k);
    chk(k, na);
    i_dmsc_host_model.xfer(idx, 1'b1, r, k);
    chk(k, na);
    foreach (d[i]) begin
      i_dmsc_host_model.xfer(d[i], 1'b1, r, k);
      chk(k, na);
    end
    chk(ctrl_bank, expb);
    i_dmsc_host_model.stop();
    i_dmsc_host_model.tick(10);
    if (!na && idx[3:0] >= 4'h1 && idx[3:0] <= 4'h9) expb[idx[3:0]-4'h1] = d[$];
    expb[8][0] = 1'b0;
    chk(ctrl_bank, expb);
  endtask
  task automatic reg_rd(input logic [7:0] idx, input int n, input logic rs);
    logic [7:0] r;
    logic k;
    i_dmsc_host_model.start();
    i_dmsc_host_model.xfer({i2c_addr_pin, 1'b0}, 1'b1, r, k);
    chk(k, 1'b0);
    i_dmsc_host_model.xfer(idx, 1'b1, r, k);
    chk(k, 1'b0);
    if (!rs) i_dmsc_host_model.stop();
    i_dmsc_host_model.start();
    i_dmsc_host_model.xfer({i2c_addr_pin, 1'b1}, 1'b1, r, k);
    chk(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_dmsc_host_model.xfer(8'hFF, i == n - 1, r, k);
      chk(r, rx(idx[3:0] + i[3:0]));
      chk(sda_o, 1'b0);
    end
    chk(sda_oe, 1'b0);
    i_dmsc_host_model.stop();
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    interface_mode_select = 1'b0;
    i2c_addr_pin = 7'h5A;
    expb = dmsc_pkg::BANK_RESET;
    f = 72'h0123456789ABCDEF03;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    i_dmsc_host_model.tick(8);
    chk(ctrl_bank, expb);
    chk({monitor_off, sequence_length_select}, 2'b10);
    reg_wr(i2c_addr_pin, 8'h03, '{8'h66}, 1'b1);
    for (int j = 0; j < 2; j++) begin
      i_dmsc_host_model.tw_shift(f, q);
      chk(q, fr(expb));
      chk(ctrl_bank, expb);
      chk(three_wire_serial_out_oe, 1'b1);
      i_dmsc_host_model.tw_end();
      chk(three_wire_serial_out_oe, 1'b0);
      for (int k = 0; k < 9; k++) begin
        expb[k] = f[71-8*k -: 8];
      end
      expb[8][0] = 1'b0;
      chk(ctrl_bank, expb);
      f = ~f;
    end
    chk({monitor_off, sequence_length_select}, 2'b10);
    interface_mode_select <= 1'b1;
    i_dmsc_host_model.tick(10);
    i_dmsc_host_model.tw_shift(f, q);
    i_dmsc_host_model.tw_end();
    chk(ctrl_bank, expb);
    reg_wr(i2c_addr_pin ^ 7'h01, 8'h02, '{8'h12}, 1'b1);
    reg_wr(i2c_addr_pin, 8'hF3, '{8'h11, 8'h55, 8'hA7}, 1'b0);
    reg_wr(i2c_addr_pin, 8'h0C, '{8'h77}, 1'b0);
    reg_wr(i2c_addr_pin, 8'h09, '{8'hFF}, 1'b0);
    chk({monitor_off, sequence_length_select}, 2'b11);
    reg_rd(8'h01, 10, 1'b1);
    reg_rd(8'h03, 1, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// File: src/dmsc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dmsc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_clean
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } dmsc_sync_t;

  dmsc_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = pin_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a bit moves only once stages two and three agree
    d.clean = (q.s2 & q.s3) | (q.clean & (q.s2 ^ q.s3));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign pin_clean = q.clean;

endmodule
`default_nettype wire

// File: src/dmsc_pkg.sv
// shared constants and types of the dual-mode serial control port
package dmsc_pkg;

  // control bank geometry
  localparam int NUM_REGS = 9;
  localparam int REG_W = 8;
  localparam int BANK_W = NUM_REGS * REG_W;

  // register indices as seen over the two-wire bus
  localparam logic [3:0] IDX_FIRST = 4'h1;
  localparam logic [3:0] IDX_LAST = 4'h9;

  // bank values after reset, leftmost entry is register 9, rightmost register 1
  localparam logic [8:0][7:0] BANK_RESET = {
    8'h80, 8'h92, 8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 8'h80, 8'h80
  };

  // field positions inside register 9 (array entry 8)
  localparam int CFG_REG = 8;
  localparam int MON_OFF_BIT = 7;
  localparam int SEQ_LEN_BIT = 1;
  localparam int ZERO_BIT = 0;

  // three-wire frame length in clock pulses
  localparam logic [6:0] TW_BITS = 7'h48;
  localparam logic [6:0] TW_CNT_RESET = 7'h00;

  // two-wire bit counting
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;

  // target address when no strap is fitted
  localparam logic [6:0] ADDR_DEFAULT = 7'h20;

  // synchroniser reset values: {mode, sel_n, tclk, tdin, scl, sda, addr[6:0]}
  localparam int SYNC_W = 13;
  localparam logic [12:0] SYNC_RESET = {1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, ADDR_DEFAULT};

  // two-wire target states
  typedef enum logic [7:0] {
    I2C_IDLE   = 8'h01,
    I2C_ADDR   = 8'h02,
    I2C_ACK    = 8'h04,
    I2C_INDEX  = 8'h08,
    I2C_WDATA  = 8'h10,
    I2C_READ   = 8'h20,
    I2C_RACK   = 8'h40,
    I2C_IGNORE = 8'h80
  } dmsc_i2c_state_t;

endpackage

// File: src/dmsc_top.sv
// dual-mode serial control port: three-wire shift port or two-wire target
// Behaviour
// - sample three-wire data on rising clock edges
// - three-wire bank updates on select rising edge
// - readback pin driven only while select low
// - mode pin low three-wire, high two-wire
// - target address from seven strap pins
// - unstrapped address reads as bit five set
// - bytes MSB first, sampled high, then acknowledge
// - foreign address ignored, target stays idle
// - write direction: acknowledge address and bytes
// - low four bits of first byte index
// - write data committed when transfer ends
// - extra write bytes overwrite same register
// - bad index acknowledged, write dropped
// - read: write index, restart, address read
// - target drives read data, controller clocks
// - controller NACK releases data line
// - controller ACK advances index, next byte
// - unlimited bytes per transfer
// - nine byte registers, numbered one to nine
// - bank loads defaults at reset
// - register nine fields, bit zero fixed zero
`timescale 1ns/1ps
`default_nettype none
module dmsc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // static configuration pins
  input wire logic interface_mode_select,
  input wire logic [6:0] i2c_addr_pin,
  // three-wire port
  input wire logic three_wire_clock_in,
  input wire logic three_wire_select_n,
  input wire logic three_wire_serial_in,
  output logic three_wire_serial_out,
  output logic three_wire_serial_out_oe,
  // two-wire port, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // control bank towards the chip
  output logic [8:0][7:0] ctrl_bank,
  output logic monitor_off,
  output logic sequence_length_select
);

  // synchronised pins
  logic [12:0] pins_clean;
  logic s_mode;
  logic s_sel_n;
  logic s_tclk;
  logic s_tdin;
  logic s_scl;
  logic s_sda;
  logic [6:0] s_addr;

  // one shared pipe keeps scl and sda aligned to each other, which START and STOP
  // detection depends on; the price is a few core clocks of latency on every pin
  dmsc_pin_sync #(
    .WIDTH(dmsc_pkg::SYNC_W),
    .RESET_VAL(dmsc_pkg::SYNC_RESET)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_raw({interface_mode_select, three_wire_select_n, three_wire_clock_in,
              three_wire_serial_in, scl_i, sda_i, i2c_addr_pin}),
    .pin_clean(pins_clean)
  );

  // the strap default lives in the synchroniser reset value
  assign {s_mode, s_sel_n, s_tclk, s_tdin, s_scl, s_sda, s_addr} = pins_clean;

  typedef struct packed {
    logic [8:0][7:0] bank;
    logic [71:0] tw_shift;
    logic [71:0] tw_out;
    logic [6:0] tw_cnt;
    logic tw_oe;
    logic tclk_prev;
    logic sel_n_prev;
    logic scl_prev;
    logic sda_prev;
    dmsc_pkg::dmsc_i2c_state_t state;
    dmsc_pkg::dmsc_i2c_state_t ack_next;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [3:0] idx;
    logic [7:0] pend;
    logic pend_v;
    logic ack_drv;
    logic mack;
    logic sda_oe;
  } dmsc_state_t;

  dmsc_state_t q, d;

  // the frame carries register 1 first while the bank keeps register 9 leftmost,
  // so both directions of the shift path swap byte lanes here
  logic [8:0][7:0] shift_as_bank;
  logic [71:0] bank_as_frame;

  for (genvar g = 0; g < dmsc_pkg::NUM_REGS; g++) begin : g_lane
    assign shift_as_bank[g] = q.tw_shift[71-8*g -: 8];
    assign bank_as_frame[71-8*g -: 8] = q.bank[g];
  end

  // index in range means registers one to nine
  function automatic logic idx_ok(input logic [3:0] idx);
    idx_ok = (idx >= dmsc_pkg::IDX_FIRST) && (idx <= dmsc_pkg::IDX_LAST);
  endfunction

  // out-of-range reads return zero rather than an undefined lane
  function automatic logic [7:0] rd_byte(input logic [8:0][7:0] bank, input logic [3:0] idx);
    logic [3:0] pos;
    pos = idx - dmsc_pkg::IDX_FIRST;
    rd_byte = 8'h00;
    if (idx_ok(idx)) begin
      rd_byte = bank[pos];
    end
  endfunction

  logic tclk_rise;
  logic tclk_fall;
  logic sel_rise;
  logic sel_fall;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic [7:0] rx_byte;
  logic [3:0] wr_pos;
  logic [7:0] next_rd;

  always_comb begin
    tclk_rise = s_tclk & ~q.tclk_prev;
    tclk_fall = ~s_tclk & q.tclk_prev;
    sel_rise = s_sel_n & ~q.sel_n_prev;
    sel_fall = ~s_sel_n & q.sel_n_prev;
    scl_rise = s_scl & ~q.scl_prev;
    scl_fall = ~s_scl & q.scl_prev;
    i2c_start = q.scl_prev & s_scl & q.sda_prev & ~s_sda;
    i2c_stop = q.scl_prev & s_scl & ~q.sda_prev & s_sda;
    rx_byte = {q.sh[6:0], s_sda};
    wr_pos = q.idx - dmsc_pkg::IDX_FIRST;
    next_rd = rd_byte(q.bank, q.idx);
  end

  always_comb begin
    d = q;
    d.tclk_prev = s_tclk;
    d.sel_n_prev = s_sel_n;
    d.scl_prev = s_scl;
    d.sda_prev = s_sda;

    // three-wire side
    // the enable follows the synchronised select, a few core clocks behind the pin
    d.tw_oe = ~s_sel_n & ~s_mode;
    if (!s_mode) begin
      if (sel_fall) begin
        // readback snapshot taken as the frame opens; register 1 goes out first
        d.tw_out = bank_as_frame;
        d.tw_cnt = dmsc_pkg::TW_CNT_RESET;
      end else if (!s_sel_n) begin
        // edges come from the synchronised pin, so each host phase must span several clocks
        if (tclk_rise) begin
          d.tw_shift = {q.tw_shift[70:0], s_tdin};
          if (q.tw_cnt != dmsc_pkg::TW_BITS) begin
            d.tw_cnt = q.tw_cnt + 7'h01;
          end
        end
        if (tclk_fall) begin
          d.tw_out = {q.tw_out[70:0], 1'h0};
        end
      end
      // a short frame is dropped so a glitch on select cannot scramble the bank
      if (sel_rise && (q.tw_cnt == dmsc_pkg::TW_BITS)) begin
        d.bank = shift_as_bank;
      end
    end

    // two-wire side
    if (!s_mode) begin
      d.state = dmsc_pkg::I2C_IDLE;
      d.sda_oe = 1'h0;
      d.ack_drv = 1'h0;
      d.mack = 1'h0;
      d.pend_v = 1'h0;
    end else if (i2c_start || i2c_stop) begin
      // repeated START and STOP both end the transfer and commit pending data
      if (q.pend_v && idx_ok(q.idx)) begin
        d.bank[wr_pos] = q.pend;
      end
      d.pend_v = 1'h0;
      d.sda_oe = 1'h0;
      d.ack_drv = 1'h0;
      d.mack = 1'h0;
      d.bitcnt = dmsc_pkg::BIT_CNT_RESET;
      d.state = i2c_start ? dmsc_pkg::I2C_ADDR : dmsc_pkg::I2C_IDLE;
    end else begin
      unique case (q.state)
        dmsc_pkg::I2C_IDLE, dmsc_pkg::I2C_IGNORE: begin
          d.sda_oe = 1'h0;
        end

        // receive side: the bit count closes a byte on its eighth rise
        dmsc_pkg::I2C_ADDR, dmsc_pkg::I2C_INDEX, dmsc_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            d.sh = rx_byte;
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == dmsc_pkg::LAST_BIT) begin
              d.bitcnt = dmsc_pkg::BIT_CNT_RESET;
              d.state = dmsc_pkg::I2C_ACK;
              if (q.state == dmsc_pkg::I2C_ADDR) begin
                if (rx_byte[7:1] != s_addr) begin
                  d.state = dmsc_pkg::I2C_IGNORE;
                end else if (rx_byte[0]) begin
                  d.ack_next = dmsc_pkg::I2C_READ;
                end else begin
                  d.ack_next = dmsc_pkg::I2C_INDEX;
                end
              end else if (q.state == dmsc_pkg::I2C_INDEX) begin
                d.idx = rx_byte[3:0];
                d.ack_next = dmsc_pkg::I2C_WDATA;
              end else begin
                // every further byte replaces the pending data, index stays
                d.pend = rx_byte;
                d.pend_v = 1'h1;
                d.ack_next = dmsc_pkg::I2C_WDATA;
              end
            end
          end
        end

        // first fall pulls the line low, the second fall lets it go, or after a read address drives bit 7 of the first read byte
        dmsc_pkg::I2C_ACK: begin
          if (scl_fall) begin
            if (!q.ack_drv) begin
              // pull low across the ninth pulse, whatever the index
              d.ack_drv = 1'h1;
              d.sda_oe = 1'h1;
            end else begin
              d.ack_drv = 1'h0;
              d.sda_oe = 1'h0;
              d.bitcnt = dmsc_pkg::BIT_CNT_RESET;
              d.state = q.ack_next;
              if (q.ack_next == dmsc_pkg::I2C_READ) begin
                d.sh = next_rd;
                d.sda_oe = ~next_rd[7];
              end
            end
          end
        end

        // pulses counted on rises; the fall after the eighth frees the line for the answer
        dmsc_pkg::I2C_READ: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && (q.bitcnt != dmsc_pkg::BIT_CNT_RESET)) begin
            if (q.bitcnt == dmsc_pkg::BYTE_BITS) begin
              d.sda_oe = 1'h0;
              d.state = dmsc_pkg::I2C_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'h0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end

        // ninth pulse: the controller's answer chooses next byte or silence
        dmsc_pkg::I2C_RACK: begin
          if (scl_rise) begin
            if (!s_sda) begin
              d.mack = 1'h1;
              d.idx = q.idx + 4'h1;
            end else begin
              // line already released; wait in I2C_IGNORE for STOP
              d.state = dmsc_pkg::I2C_IGNORE;
            end
          end
          if (scl_fall && q.mack) begin
            d.mack = 1'h0;
            d.bitcnt = dmsc_pkg::BIT_CNT_RESET;
            d.sh = next_rd;
            d.sda_oe = ~next_rd[7];
            d.state = dmsc_pkg::I2C_READ;
          end
        end

        // a corrupted state code falls back to idle rather than holding the bus
        default: begin
          d.state = dmsc_pkg::I2C_IDLE;
          d.sda_oe = 1'h0;
        end
      endcase
    end

    // forced after both ports so neither path can ever set the fixed bit
    d.bank[dmsc_pkg::CFG_REG][dmsc_pkg::ZERO_BIT] = 1'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // power-up defaults, no host command needed
      q.bank <= dmsc_pkg::BANK_RESET;
      q.tw_shift <= '0;
      q.tw_out <= '0;
      q.tw_cnt <= dmsc_pkg::TW_CNT_RESET;
      q.tw_oe <= 1'h0;
      q.tclk_prev <= 1'h0;
      q.sel_n_prev <= 1'h1;
      q.scl_prev <= 1'h1;
      q.sda_prev <= 1'h1;
      q.state <= dmsc_pkg::I2C_IDLE;
      q.ack_next <= dmsc_pkg::I2C_IDLE;
      q.bitcnt <= dmsc_pkg::BIT_CNT_RESET;
      q.sh <= 8'h00;
      q.idx <= 4'h0;
      q.pend <= 8'h00;
      q.pend_v <= 1'h0;
      q.ack_drv <= 1'h0;
      q.mack <= 1'h0;
      q.sda_oe <= 1'h0;
    end else begin
      q <= d;
    end
  end

  // outputs are flop bits; sda is open drain so its data is always low
  assign three_wire_serial_out = q.tw_out[71];
  assign three_wire_serial_out_oe = q.tw_oe;
  assign sda_o = 1'h0;
  assign sda_oe = q.sda_oe;
  assign ctrl_bank = q.bank;
  assign monitor_off = q.bank[dmsc_pkg::CFG_REG][dmsc_pkg::MON_OFF_BIT];
  assign sequence_length_select = q.bank[dmsc_pkg::CFG_REG][dmsc_pkg::SEQ_LEN_BIT];

endmodule
`default_nettype wire
